// >>> design/cansit_pkg.sv
/*
  Shared constants and types for the message object status and identifier tag block.
  Assumes one 50 MHz controller clock and a protocol engine on that same clock.
*/
`default_nettype none
package cansit_pkg;
  localparam int unsigned NOBJ = 15;
  localparam logic [7:0] ADDR_PAGE = 8'hb1;
  localparam logic [7:0] ADDR_STATUS = 8'hb2;
  localparam logic [7:0] ADDR_CTRL = 8'hb3;
  localparam logic [7:0] ADDR_TAG1 = 8'hbc;
  localparam logic [7:0] ADDR_TAG2 = 8'hbd;
  localparam logic [7:0] ADDR_TAG3 = 8'hbe;
  localparam logic [7:0] ADDR_TAG4 = 8'hbf;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int unsigned ST_LENGTH_MISMATCH_WARNING = 7;
  localparam int unsigned ST_TRANSMIT_COMPLETE = 6;
  localparam int unsigned ST_RECEIVE_COMPLETE = 5;
  localparam int unsigned ST_BIT_ERROR_FLAG = 4;
  localparam int unsigned ST_STUFF_ERROR_FLAG = 3;
  localparam int unsigned ST_CRC_ERROR_FLAG = 2;
  localparam int unsigned ST_FORM_ERROR_FLAG = 1;
  localparam int unsigned ST_ACK_ERROR_FLAG = 0;
  localparam int unsigned CTRL_IDE = 4;
  localparam logic [1:0] CFG_DISABLE = 2'h0;
  localparam logic [1:0] CFG_TX = 2'h1;
  localparam logic [1:0] CFG_RX = 2'h2;
  localparam logic [7:0] STD_TAG2_MASK = 8'he0;
  localparam logic [7:0] STD_TAG4_MASK = 8'h05;
  localparam logic [14:0] CRC_POLY = 15'h4599;
  localparam logic [2:0] STUFF_LIMIT = 3'h5;
  localparam logic [3:0] NO_OBJECT = 4'hf;

  // Per-cycle view of the protocol engine, one bit time per bit_valid.
  typedef struct packed {
    logic sof;
    logic bit_valid;
    logic driven;
    logic monitored;
    logic transmitting;
    logic arbitration;
    logic ack_slot;
    logic error_frame;
    logic stuff_zone;
    logic crc_zone;
    logic crc_check;
    logic [14:0] crc_rx;
    logic form_check;
    logic tx_done;
    logic rx_done;
    logic [3:0] rx_dlc;
    logic [14:0] rx_hit;
    logic [3:0] err_obj;
  } cansit_eng_t;
endpackage
`default_nettype wire

// >>> design/cansit_top.sv
/*
  Per-object status flags, control/length and identifier tags of a CAN controller,
  reached through the byte-wide special-function-register port.
  Assumes the protocol engine runs on CLK and presents bit-level and frame events.
*/
`default_nettype none
// What this block does
// - Flag status bit 7 when a received length code differs from the expected one.
// - A frame received into an enabled object overwrites that object's length code with the received code.
// - Set status bit 6 when the object's enabled transmission completes.
// - Among objects enabled to transmit, the lowest index is served first.
// - Set status bit 5 when the object's enabled reception completes.
// - A frame hitting several receive objects updates only the lowest index.
// - While transmitting, set status bit 4 when monitored level differs from driven.
// - No bit error for recessive lost in arbitration or dominant ack in error frame.
// - Set status bit 3 on more than five equal bits where stuffing applies.
// - Receiver CRC over destuffed SOF to data; mismatch sets status bit 2.
// - Set status bit 1 on a malformed CRC delimiter, ack delimiter or end of frame.
// - Set status bit 0 when no dominant level is seen in our ack slot.
// - Flags stay set until software clears them; hardware never clears them.
// - Standard format: id 10..3 in tag 1, id 2..0 in tag 2 bits 7-5.
// - Standard format: tag 3 reserved; tag 4 holds remote bit 2, reserved-bit-0 bit 0.
// - Extended format: tags 1,2,3 hold id 28..21, 20..13, 12..5.
// - Identifier tags have no value after reset.
// - The identifier extension bit picks the 11-bit or 29-bit tag layout.
// - The page object-number field, 0 to 14, picks the visible object.
module cansit_top
  import cansit_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  output logic [7:0] SFR_RDATA,
  input wire cansit_eng_t ENG,
  output logic TX_VALID,
  output logic [3:0] TX_OBJ,
  output logic TX_IDE,
  output logic [28:0] TX_ID,
  output logic [3:0] TX_DLC
);

  // Returns {found, index} of the lowest set bit.
  function automatic logic [4:0] cansit_first(input logic [14:0] v);
    logic [4:0] r;
    r = {1'b0, NO_OBJECT};
    for (int i = NOBJ - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [28:0] cansit_id(input logic identifier_extension, input logic [7:0] t1,
                                            input logic [7:0] t2, input logic [7:0] t3,
                                            input logic [7:0] t4);
    if (identifier_extension) begin
      return {t1, t2, t3, t4[7:3]};
    end
    return {18'h0, t1, t2[7:5]};
  endfunction

  logic [7:0] page_reg, page_next;
  logic [7:0] status_reg [NOBJ], status_next [NOBJ];
  logic [7:0] ctrl_reg [NOBJ], ctrl_next [NOBJ];
  logic [7:0] tag_reg [NOBJ][4], tag_next [NOBJ][4];
  logic [2:0] run_reg, run_next;
  logic last_reg, last_next;
  logic [14:0] crc_reg, crc_next;
  logic [7:0] rdata_reg, rdata_next;
  logic tx_valid_reg, tx_valid_next;
  logic [3:0] tx_obj_reg, tx_obj_next;
  logic tx_ide_reg, tx_ide_next;
  logic [28:0] tx_id_reg, tx_id_next;
  logic [3:0] tx_dlc_reg, tx_dlc_next;

  logic [3:0] sel;
  logic sel_ok;
  logic [14:0] tx_en, rx_en;
  logic [4:0] tx_pick, rx_pick;
  logic bit_error_flag_ev, stuff_error_flag_ev, crc_error_flag_ev, form_error_flag_ev, ack_error_flag_ev;
  logic err_ok;

  assign sel = page_reg[7:4];
  assign sel_ok = (sel < 4'(NOBJ));
  assign err_ok = (ENG.err_obj < 4'(NOBJ));

  always_comb begin
    for (int i = 0; i < NOBJ; i++) begin
      tx_en[i] = (ctrl_reg[i][7:6] == CFG_TX);
      rx_en[i] = ctrl_reg[i][7];
    end
  end

  assign tx_pick = cansit_first(tx_en);
  assign rx_pick = cansit_first(ENG.rx_hit & rx_en);

  // Bus error detectors; monitored levels are 1 for recessive.
  assign bit_error_flag_ev = ENG.bit_valid && ENG.transmitting && (ENG.driven != ENG.monitored)
                   && !(ENG.arbitration && ENG.driven && !ENG.monitored)
                   && !(ENG.ack_slot && ENG.error_frame);
  assign stuff_error_flag_ev = ENG.bit_valid && ENG.stuff_zone && (run_reg == STUFF_LIMIT)
                   && (ENG.monitored == last_reg);
  assign crc_error_flag_ev = ENG.crc_check && !ENG.transmitting && (ENG.crc_rx != crc_reg);
  assign form_error_flag_ev = ENG.bit_valid && ENG.form_check && !ENG.monitored;
  assign ack_error_flag_ev = ENG.bit_valid && ENG.ack_slot && ENG.transmitting
                   && !ENG.error_frame && ENG.monitored;

  // Bit-run and CRC tracking.
  always_comb begin
    run_next = run_reg;
    last_next = last_reg;
    crc_next = crc_reg;
    if (ENG.sof) begin
      crc_next = 15'h0000;
    end
    if (ENG.bit_valid) begin
      last_next = ENG.monitored;
      if (!ENG.stuff_zone || ENG.monitored != last_reg) begin
        run_next = 3'h1;
      end else if (run_reg != 3'h7) begin
        run_next = run_reg + 3'h1;
      end
    end
    if (ENG.bit_valid && ENG.crc_zone && !ENG.sof) begin
      crc_next = {crc_reg[13:0], 1'b0}
                 ^ ((ENG.monitored ^ crc_reg[14]) ? CRC_POLY : 15'h0000);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      run_reg <= 3'h0;
      last_reg <= 1'b1;
      crc_reg <= 15'h0000;
    end else begin
      run_reg <= run_next;
      last_reg <= last_next;
      crc_reg <= crc_next;
    end
  end

  // Register file next state; hardware sets win over software writes.
  always_comb begin
    page_next = page_reg;
    if (SFR_WR && SFR_ADDR == ADDR_PAGE) begin
      page_next = SFR_WDATA;
    end
    for (int i = 0; i < NOBJ; i++) begin
      status_next[i] = status_reg[i];
      ctrl_next[i] = ctrl_reg[i];
      for (int k = 0; k < 4; k++) begin
        tag_next[i][k] = tag_reg[i][k];
      end
      if (SFR_WR && sel_ok && sel == 4'(i)) begin
        if (SFR_ADDR == ADDR_STATUS) status_next[i] = SFR_WDATA;
        if (SFR_ADDR == ADDR_CTRL) ctrl_next[i] = SFR_WDATA;
        if (SFR_ADDR == ADDR_TAG1) tag_next[i][0] = SFR_WDATA;
        if (SFR_ADDR == ADDR_TAG2) tag_next[i][1] = SFR_WDATA;
        if (SFR_ADDR == ADDR_TAG3) tag_next[i][2] = SFR_WDATA;
        if (SFR_ADDR == ADDR_TAG4) tag_next[i][3] = SFR_WDATA;
      end
      if (ENG.tx_done && tx_pick[4] && tx_pick[3:0] == 4'(i)) begin
        status_next[i][ST_TRANSMIT_COMPLETE] = 1'b1;
        ctrl_next[i][7:6] = CFG_DISABLE;
      end
      if (ENG.rx_done && rx_pick[4] && rx_pick[3:0] == 4'(i)) begin
        status_next[i][ST_RECEIVE_COMPLETE] = 1'b1;
        if (ENG.rx_dlc != ctrl_reg[i][3:0]) begin
          status_next[i][ST_LENGTH_MISMATCH_WARNING] = 1'b1;
        end
        ctrl_next[i][3:0] = ENG.rx_dlc;
        if (ctrl_reg[i][7:6] == CFG_RX) begin
          ctrl_next[i][7:6] = CFG_DISABLE;
        end
      end
      if (err_ok && ENG.err_obj == 4'(i)) begin
        status_next[i] = status_next[i] | ({7'h00, ack_error_flag_ev} << ST_ACK_ERROR_FLAG)
                         | ({7'h00, form_error_flag_ev} << ST_FORM_ERROR_FLAG) | ({7'h00, crc_error_flag_ev} << ST_CRC_ERROR_FLAG)
                         | ({7'h00, stuff_error_flag_ev} << ST_STUFF_ERROR_FLAG)
                         | ({7'h00, bit_error_flag_ev} << ST_BIT_ERROR_FLAG);
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      page_reg <= PAGE_RESET;
      for (int i = 0; i < NOBJ; i++) begin
        status_reg[i] <= STATUS_RESET;
        ctrl_reg[i] <= CTRL_RESET;
      end
    end else begin
      page_reg <= page_next;
      status_reg <= status_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // Tags carry no reset so software must load them before use.
  always_ff @(posedge CLK) begin
    tag_reg <= tag_next;
  end

  // Read mux; reserved tag bits read as zero in the standard layout.
  always_comb begin
    rdata_next = rdata_reg;
    if (SFR_RD) begin
      rdata_next = 8'h00;
      if (SFR_ADDR == ADDR_PAGE) begin
        rdata_next = page_reg;
      end else if (sel_ok) begin
        case (SFR_ADDR)
          ADDR_STATUS: rdata_next = status_reg[sel];
          ADDR_CTRL: rdata_next = ctrl_reg[sel];
          ADDR_TAG1: rdata_next = tag_reg[sel][0];
          ADDR_TAG2: rdata_next = ctrl_reg[sel][CTRL_IDE] ? tag_reg[sel][1]
                                  : (tag_reg[sel][1] & STD_TAG2_MASK);
          ADDR_TAG3: rdata_next = ctrl_reg[sel][CTRL_IDE] ? tag_reg[sel][2]
                                  : 8'h00;
          ADDR_TAG4: rdata_next = ctrl_reg[sel][CTRL_IDE] ? tag_reg[sel][3]
                                  : (tag_reg[sel][3] & STD_TAG4_MASK);
          default: rdata_next = 8'h00;
        endcase
      end
    end
  end

  // Transmit candidate presented to the engine.
  always_comb begin
    tx_valid_next = tx_pick[4];
    tx_obj_next = tx_pick[3:0];
    tx_ide_next = 1'b0;
    tx_id_next = 29'h0;
    tx_dlc_next = 4'h0;
    if (tx_pick[4]) begin
      tx_ide_next = ctrl_reg[tx_pick[3:0]][CTRL_IDE];
      tx_dlc_next = ctrl_reg[tx_pick[3:0]][3:0];
      tx_id_next = cansit_id(tx_ide_next, tag_reg[tx_pick[3:0]][0],
                             tag_reg[tx_pick[3:0]][1], tag_reg[tx_pick[3:0]][2],
                             tag_reg[tx_pick[3:0]][3]);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
      tx_obj_reg <= 4'h0;
      tx_ide_reg <= 1'b0;
      tx_id_reg <= 29'h0;
      tx_dlc_reg <= 4'h0;
    end else begin
      rdata_reg <= rdata_next;
      tx_valid_reg <= tx_valid_next;
      tx_obj_reg <= tx_obj_next;
      tx_ide_reg <= tx_ide_next;
      tx_id_reg <= tx_id_next;
      tx_dlc_reg <= tx_dlc_next;
    end
  end

  assign SFR_RDATA = rdata_reg;
  assign TX_VALID = tx_valid_reg;
  assign TX_OBJ = tx_obj_reg;
  assign TX_IDE = tx_ide_reg;
  assign TX_ID = tx_id_reg;
  assign TX_DLC = tx_dlc_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_length_mismatch_warning;
    ENG.rx_done && rx_pick[4] && (ENG.rx_dlc != ctrl_reg[rx_pick[3:0]][3:0])
      |=> status_reg[$past(rx_pick[3:0])][ST_LENGTH_MISMATCH_WARNING];
  endproperty
  a_length_mismatch_warning: assert property (p_length_mismatch_warning) else $error("length warning not set");

  property p_dlc_update;
    ENG.rx_done && rx_pick[4] |=> ctrl_reg[$past(rx_pick[3:0])][3:0] == $past(ENG.rx_dlc);
  endproperty
  a_dlc_update: assert property (p_dlc_update) else $error("length code not updated");

  property p_transmit_complete;
    ENG.tx_done && tx_pick[4] |=> status_reg[$past(tx_pick[3:0])][ST_TRANSMIT_COMPLETE];
  endproperty
  a_transmit_complete: assert property (p_transmit_complete) else $error("transmit flag not set");

  property p_tx_lowest;
    tx_pick[4] |-> ((tx_en & ((15'h0001 << tx_pick[3:0]) - 15'h0001)) == 15'h0000)
                   && tx_en[tx_pick[3:0]];
  endproperty
  a_tx_lowest: assert property (p_tx_lowest) else $error("transmit not lowest");

  property p_receive_complete;
    ENG.rx_done && rx_pick[4] |=> status_reg[$past(rx_pick[3:0])][ST_RECEIVE_COMPLETE];
  endproperty
  a_receive_complete: assert property (p_receive_complete) else $error("receive flag not set");

  property p_no_arb_bit_error_flag;
    ENG.arbitration && ENG.driven && !ENG.monitored |-> !bit_error_flag_ev;
  endproperty
  a_no_arb_bit_error_flag: assert property (p_no_arb_bit_error_flag) else $error("bit error in arbitration");

  property p_stuff;
    ENG.bit_valid && ENG.stuff_zone && err_ok && run_reg == STUFF_LIMIT
      && ENG.monitored == last_reg |=> status_reg[$past(ENG.err_obj)][ST_STUFF_ERROR_FLAG];
  endproperty
  a_stuff: assert property (p_stuff) else $error("stuff error not set");

  property p_ack;
    ack_error_flag_ev && err_ok |=> status_reg[$past(ENG.err_obj)][ST_ACK_ERROR_FLAG];
  endproperty
  a_ack: assert property (p_ack) else $error("ack error not set");

  property p_sticky;
    sel_ok && !(SFR_WR && SFR_ADDR == ADDR_STATUS)
      |=> (status_reg[$past(sel)] & $past(status_reg[sel])) == $past(status_reg[sel]);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared by hardware");

endmodule
`default_nettype wire

// >>> tb/cansit_node.sv
/*
  Model of the protocol engine and the remote nodes behind it: drives the engine event bundle.
  Assumes the bench calls its tasks and that CLK is the controller clock.
*/
`default_nettype none
module cansit_node
  import cansit_pkg::*;
(
  input wire logic CLK,
  output cansit_eng_t ENG
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    ENG = '{err_obj: NO_OBJECT, default: '0};
  end

  // Bus levels flip between bit times so stale levels are never mistaken for data.
  task automatic idle();
    ENG <= '{err_obj: NO_OBJECT, driven: ~ENG.driven, monitored: ~ENG.monitored, default: '0};
  endtask

  task automatic drive(input cansit_eng_t e, input int n);
    repeat (n) begin
      @(negedge CLK);
      ENG <= e;
    end
    @(negedge CLK);
    idle();
  endtask

  // Start of frame always precedes the checked bits, and the check follows them.
  task automatic crc_frame(input logic [3:0] obj, input logic [31:0] bits, input int n,
                           input logic [14:0] crc);
    drive('{sof: 1'b1, err_obj: obj, default: '0}, 1);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge CLK);
      ENG <= '{bit_valid: 1'b1, crc_zone: 1'b1, driven: bits[i], monitored: bits[i],
               err_obj: obj, default: '0};
    end
    drive('{crc_check: 1'b1, crc_rx: crc, err_obj: obj, default: '0}, 1);
  endtask
endmodule
`default_nettype wire

// >>> tb/can_msg_object_status_and_id_tag_bench.sv
/*
  Self-checking bench for the status flags and identifier tags of the message objects.
  Assumes the design package, the design top and the engine model are compiled first.
*/
`default_nettype none
module can_msg_object_status_and_id_tag_bench
  import cansit_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rdata;
  cansit_eng_t eng;
  logic tx_valid;
  logic [3:0] tx_obj;
  logic tx_ide;
  logic [28:0] tx_id;
  logic [3:0] tx_dlc;
  int errors = 0;
  int cmp_count = 0;
  logic [7:0] tag_mem [15][4];
  logic ide_mem [15];
  logic [7:0] d;
  logic [31:0] dd;
  logic [14:0] c;
  int dl;

  always #10 clk = ~clk;

  cansit_top cansit_top_inst (.CLK(clk), .RST(rst), .SFR_ADDR(addr), .SFR_WDATA(wdata),
    .SFR_WR(wr_en), .SFR_RD(rd_en), .SFR_RDATA(rdata), .ENG(eng), .TX_VALID(tx_valid),
    .TX_OBJ(tx_obj), .TX_IDE(tx_ide), .TX_ID(tx_id), .TX_DLC(tx_dlc));
  cansit_node cansit_node_inst (.CLK(clk), .ENG(eng));

  task automatic summarize();
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    v = rdata;
  endtask

  task automatic page(input logic [3:0] o);
    wr(ADDR_PAGE, {o, 4'h0});
  endtask

  // Standard layout shows only the identifier and tag bits; reserved ones are expected to read as zero.
  function automatic logic [7:0] tag_exp(int k, logic identifier_extension, logic [7:0] v);
    if (identifier_extension) begin
      return v;
    end
    case (k)
      0: return v;
      1: return v & STD_TAG2_MASK;
      2: return 8'h00;
      default: return v & STD_TAG4_MASK;
    endcase
  endfunction

  function automatic logic [14:0] crc15(logic [31:0] b, int n);
    logic [14:0] r;
    logic nx;
    r = '0;
    for (int i = n - 1; i >= 0; i--) begin
      nx = b[i] ^ r[14];
      r = {r[13:0], 1'b0};
      if (nx) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction

  function automatic cansit_eng_t ev(logic tx, logic arb, logic ack, logic ef, logic sz,
                                     logic fc, logic drv, logic mon);
    return '{bit_valid: 1'b1, transmitting: tx, arbitration: arb, ack_slot: ack,
             error_frame: ef, stuff_zone: sz, form_check: fc, driven: drv, monitored: mon,
             err_obj: 4'h9, default: '0};
  endfunction

  task automatic err_case(input cansit_eng_t e, input int n, input logic [7:0] exp);
    cansit_node_inst.drive(e, n);
    rd(ADDR_STATUS, d);
    chk("error status", exp, d);
    wr(ADDR_STATUS, 8'h00);
  endtask

  initial begin
    dl = $urandom(62);
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd(ADDR_PAGE, d);
    chk("page reset", PAGE_RESET, d);
    rd(ADDR_STATUS, d);
    chk("status reset", STATUS_RESET, d);
    for (int i = 0; i < 15; i++) begin
      page(i[3:0]);
      ide_mem[i] = 1'($urandom);
      wr(ADDR_CTRL, {3'h0, ide_mem[i], 4'h0});
      for (int k = 0; k < 4; k++) begin
        tag_mem[i][k] = tag_exp(k, ide_mem[i], 8'($urandom));
        wr(ADDR_TAG1 + 8'(k), tag_mem[i][k]);
      end
    end
    for (int p = 0; p < 2; p++) begin
      for (int i = 14; i >= 0; i--) begin
        page(i[3:0]);
        for (int k = 0; k < 4; k++) begin
          rd(ADDR_TAG1 + 8'(k), d);
          chk("id tag", tag_exp(k, ide_mem[i], tag_mem[i][k]), d);
        end
        wr(ADDR_CTRL, 8'h00);
        ide_mem[i] = 1'b0;
      end
    end
    page(4'hf);
    rd(ADDR_STATUS, d);
    chk("absent object", 8'h00, d);
    page(4'h7);
    wr(ADDR_CTRL, 8'h50);
    page(4'h2);
    wr(ADDR_TAG1, 8'ha5);
    wr(ADDR_TAG2, 8'h60);
    wr(ADDR_CTRL, 8'h43);
    repeat (2) @(negedge clk);
    chk("tx valid", 1, tx_valid);
    chk("tx object", 2, tx_obj);
    chk("tx id", {8'ha5, 3'h3}, tx_id[10:0]);
    chk("tx length", 3, tx_dlc);
    chk("tx ext", 0, tx_ide);
    cansit_node_inst.drive('{tx_done: 1'b1, err_obj: NO_OBJECT, default: '0}, 1);
    rd(ADDR_STATUS, d);
    chk("tx status", 8'h40, d);
    chk("next tx object", 7, tx_obj);
    chk("next tx ext", 1, tx_ide);
    chk("next tx id", {tag_mem[7][0], tag_mem[7][1], tag_mem[7][2], tag_mem[7][3][7:3]},
        tx_id);
    for (int j = 0; j < 2; j++) begin
      page(4'h5);
      wr(ADDR_CTRL, 8'h84);
      page(4'h3);
      wr(ADDR_CTRL, 8'h84);
      dl = (j == 0) ? 4 : $urandom % 9;
      cansit_node_inst.drive('{rx_done: 1'b1, rx_dlc: dl[3:0], rx_hit: 15'h0028,
                               err_obj: NO_OBJECT, default: '0}, 1);
      rd(ADDR_STATUS, d);
      chk("rx status", (dl == 4) ? 8'h20 : 8'ha0, d);
      rd(ADDR_CTRL, d);
      chk("rx length", dl, d[3:0]);
      repeat (30) @(negedge clk);
      rd(ADDR_STATUS, d);
      chk("held status", (dl == 4) ? 8'h20 : 8'ha0, d);
      wr(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS, d);
      chk("cleared status", 8'h00, d);
    end
    page(4'h9);
    wr(ADDR_CTRL, 8'h80);
    err_case(ev(1, 0, 0, 0, 0, 0, 1, 0), 1, 8'h10);
    err_case(ev(1, 1, 0, 0, 0, 0, 1, 0), 1, 8'h00);
    err_case(ev(1, 0, 1, 1, 0, 0, 1, 0), 1, 8'h00);
    err_case(ev(0, 0, 0, 0, 1, 0, 1, 1), 6, 8'h08);
    err_case(ev(0, 0, 0, 0, 1, 0, 0, 0), 5, 8'h00);
    err_case(ev(0, 0, 0, 0, 0, 1, 0, 0), 1, 8'h02);
    err_case(ev(1, 0, 1, 0, 0, 0, 1, 1), 1, 8'h01);
    for (int j = 0; j < 2; j++) begin
      dd = $urandom;
      c = crc15(dd, 32) ^ 15'(j);
      cansit_node_inst.crc_frame(4'h9, dd, 32, c);
      rd(ADDR_STATUS, d);
      chk("crc status", (j == 0) ? 8'h00 : 8'h04, d);
      wr(ADDR_STATUS, 8'h00);
    end
    summarize();
  end

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule
`default_nettype wire
